//--- tb/mcg_checker.sv
// Port assertions for the mirror command generator.
`timescale 1ns/100ps
module mcg_checker
  import mcg_pkg::*;
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic vol_ready_out,
  input wire logic out_valid_out,
  input wire logic out_ready_in,
  input wire mcg_word_t out_word_out,
  input wire logic step_done_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);

  chk_out_hold: assert property (
    out_valid_out && !out_ready_in |=>
    out_valid_out && $stable(out_word_out))
    else $error("output word changed under stall");
  chk_done_once: assert property (
    step_done_out |=> !step_done_out)
    else $error("completion flag longer than one cycle");
  chk_done_word: assert property (
    step_done_out |-> ##[0:1] out_valid_out)
    else $error("completion flag without output word");
  chk_stage_order: assert property (
    out_valid_out && out_word_out.kind != KIND_TILT |-> !vol_ready_out)
    else $error("intake reopened before outputs finished");
  chk_proc_runs: assert property (
    $fell(vol_ready_out) |-> ##[1:1000] out_valid_out)
    else $error("no output after intake closed");
  chk_last_tilt: assert property (
    out_valid_out && out_word_out.last |->
    out_word_out.kind == KIND_TILT && out_word_out.idx == 8'h09)
    else $error("last flag on wrong word");
  chk_tilt_range: assert property (
    out_valid_out && out_word_out.kind == KIND_TILT |->
    out_word_out.idx < NTILT)
    else $error("tilt index out of range");
  chk_grid_range: assert property (
    out_valid_out && out_word_out.kind != KIND_TILT |->
    out_word_out.idx < NE)
    else $error("grid index out of range");
endmodule

bind mcg_top mcg_checker u_chk (
  .clk_in(clk_in),
  .arst_n_in(arst_n_in),
  .vol_ready_out(vol_ready_out),
  .out_valid_out(out_valid_out),
  .out_ready_in(out_ready_in),
  .out_word_out(out_word_out),
  .step_done_out(step_done_out)
);

//--- tb/mcg_sink.sv
// Receiver model standing where the mirror drivers take the output words.
`timescale 1ns/100ps
module mcg_sink
  import mcg_pkg::*;
(
  input wire logic clk_in,
  input wire logic valid_in,
  input wire mcg_word_t word_in,
  input wire logic slow_in,
  output logic ready_out
);
  mcg_word_t got[$];
  int seed = 32'h459d;
  initial ready_out = 1'b0;
  // A slow receiver refuses most cycles so that the buffer really fills.
  always @(negedge clk_in) begin
    ready_out <= slow_in ? (($random(seed) & 3) == 0) : 1'b1;
  end
  always @(posedge clk_in) begin
    if (valid_in === 1'b1 && ready_out === 1'b1) begin
      got.push_back(word_in);
    end
  end
endmodule

//--- tb/mirror_command_generator_test.sv
// Self-checking bench for the mirror command generator.
`timescale 1ns/100ps
module mirror_command_generator_test
  import mcg_pkg::*;
;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic vol_valid_in = 1'b0;
  logic signed [DW-1:0] vol_data_in = 16'h0;
  logic load_valid_in = 1'b0;
  mcg_load_t load_in = '0;
  logic [AW-1:0] cov_raddr_in = 8'h0;
  logic slow = 1'b0;
  logic vol_ready_out, out_valid_out, out_ready_in, step_done_out;
  logic signed [DW-1:0] cov_rdata_out;
  mcg_word_t out_word_out;
  mcg_word_t ex[42];
  int num_errors = 0;
  int comparisons = 0;
  int seed = 32'h459d;
  int dones = 0;
  logic signed [DW-1:0] bt[16], wt[16], pt[16], kt[256], lt[256], et[120];
  logic signed [DW-1:0] vol[64], ms[12], ph[16], cm[16], tw[16], fp[16];

  always #50 clk_in = ~clk_in;
  always @(negedge clk_in) begin
    if (step_done_out === 1'b1) begin
      dones++;
    end
  end

  mcg_top u_dut (.clk_in, .arst_n_in, .vol_valid_in, .vol_data_in,
    .vol_ready_out, .load_valid_in, .load_in, .cov_raddr_in,
    .cov_rdata_out, .out_valid_out, .out_ready_in, .out_word_out,
    .step_done_out);
  mcg_sink u_sink (.clk_in(clk_in), .valid_in(out_valid_out),
    .word_in(out_word_out), .slow_in(slow), .ready_out(out_ready_in));

  task automatic test_done;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [42:0] s, e);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, s);
    end
  endtask

  // A wait that runs out ends the run as a failure.
  task automatic bound(input int n);
    if (n > 3000) begin
      num_errors++;
      test_done();
    end
  endtask

  function automatic logic [15:0] rnd();
    return 16'($random(seed));
  endfunction

  function automatic logic signed [15:0] mul(input logic signed [15:0] a, b);
    logic signed [31:0] p;
    p = a * b;
    return p[29:14];
  endfunction

  // Mirror index within one axis: odd bands run backwards.
  function automatic int rp(input int c);
    return ((c / 2) % 2) ? 1 - c % 2 : c % 2;
  endfunction

  task automatic ld(input logic [3:0] s, input int a, input logic [15:0] d);
    load_valid_in = 1'b1;
    load_in = '{s, a[7:0], d};
    @(negedge clk_in);
  endtask

  function automatic void calc();
    logic signed [15:0] d, f, a;
    for (int e = 0; e < 16; e++) begin
      ph[e] = vol[4*e] + vol[4*e+1] + vol[4*e+2] + vol[4*e+3];
      cm[e] = (e % 4 < 2 && e / 4 < 2) ? mul(bt[e], ph[e]) : 16'h0;
    end
    for (int e = 0; e < 16; e++) begin
      a = cm[rp(e / 4) * 4 + rp(e % 4)];
      tw[e] = ph[e] - mul(wt[e], a);
      fp[e] = mul(pt[e], tw[e]);
      ex[e] = '{KIND_WOOF, 1'b0, e[7:0], a, mul(wt[e], a)};
    end
    for (int u = 0; u < 16; u++) begin
      d = 16'h0;
      f = 16'h0;
      for (int g = 0; g < 16; g++) begin
        d += mul(kt[u*16+g], tw[g]);
        f += mul(kt[u*16+g], fp[g]);
      end
      ex[16+u] = '{KIND_TWEET, 1'b0, u[7:0],
        lt[{~f[15], f[14:12], ~d[15], d[14:12]}], d};
    end
    for (int i = 0; i < 10; i++) begin
      d = 16'h0;
      for (int j = 0; j < 12; j++) begin
        d += mul(et[i*12+j], ms[j]);
      end
      ex[32+i] = '{KIND_TILT, i == 9, i[7:0], d, 16'h0};
    end
  endfunction

  task automatic run_step(input int k);
    int n;
    mcg_word_t w;
    for (int i = 0; i < 76; i++) begin
      if (i < 64) begin
        vol[i] = (k == 1 && i % 5 == 0) ? 16'h8000 : rnd();
      end else begin
        ms[i-64] = rnd();
      end
      vol_data_in = i < 64 ? vol[i] : ms[i-64];
      vol_valid_in = 1'b1;
      n = 0;
      while (vol_ready_out !== 1'b1) begin
        n++;
        bound(n);
        @(negedge clk_in);
      end
      @(negedge clk_in);
    end
    vol_valid_in = 1'b0;
    chk("intake_closed", 43'(vol_ready_out), 43'h0);
    calc();
    n = 0;
    while (u_sink.got.size() < 42) begin
      n++;
      bound(n);
      @(negedge clk_in);
    end
    for (int i = 0; i < 42; i++) begin
      w = u_sink.got[i];
      if (i < 16) begin
        chk("woofer", w, ex[i]);
      end else if (i < 32) begin
        chk("tweeter", w, ex[i]);
      end else begin
        chk("tilt", w, ex[i]);
      end
    end
    u_sink.got.delete();
  endtask

  initial begin
    repeat (12) @(posedge clk_in);
    @(negedge clk_in);
    arst_n_in = 1'b1;
    repeat (2) @(negedge clk_in);
    for (int i = 0; i < 256; i++) begin
      kt[i] = rnd();
      lt[i] = rnd();
      ld(M_KER, i, kt[i]);
      ld(M_LUT, i, lt[i]);
      if (i < 120) begin
        et[i] = rnd();
        ld(M_EST, i, et[i]);
      end
      if (i < 16) begin
        bt[i] = rnd();
        wt[i] = rnd();
        pt[i] = rnd();
        ld(M_B, i, bt[i]);
        ld(M_W, i, wt[i]);
        ld(M_PHI, i, pt[i]);
        ld(M_COV, i, 16'(i * 3 + 1));
      end
    end
    load_valid_in = 1'b0;
    for (int i = 0; i < 16; i++) begin
      cov_raddr_in = i[7:0];
      @(negedge clk_in);
      chk("covariance", cov_rdata_out, 43'(i * 3 + 1));
    end
    for (int k = 0; k < 3; k++) begin
      slow = k == 1;
      run_step(k);
    end
    chk("done_pulses", 43'(dones), 43'h3);
    test_done();
  end
endmodule

//--- verilog/mcg_mem.sv
// Small table memory with a registered read port.
`timescale 1ns/100ps
module mcg_mem
  import mcg_pkg::*;
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic signed [DW-1:0] wr_data_in,
  input wire logic [AW-1:0] rd_addr_in,
  output logic signed [DW-1:0] rd_data_out
);

  logic signed [DW-1:0] mem_q [2**AW];
  logic signed [DW-1:0] rd_d;
  logic signed [DW-1:0] rd_q;

  // A read of the word being written returns the old contents.
  always_comb begin
    rd_d = mem_q[rd_addr_in];
  end

  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_q <= '0;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign rd_data_out = rd_q;

endmodule

//--- verilog/mcg_pkg.sv
// Shared constants, carriers and arithmetic for the mirror command generator.
package mcg_pkg;

  localparam int DW = 16;
  localparam int AW = 8;
  localparam int FRAC = 14;
  localparam int NG = 4;
  localparam int CW = 2;
  localparam int NE = 16;
  localparam int NL = 4;
  localparam int FW = 2;
  localparam int NMEAS = 12;
  localparam int NTILT = 10;
  localparam int NMEM = 12;
  localparam int NLOAD = 7;
  localparam int LUT_BITS = 4;

  localparam logic [3:0] M_B = 4'h0;
  localparam logic [3:0] M_W = 4'h1;
  localparam logic [3:0] M_PHI = 4'h2;
  localparam logic [3:0] M_KER = 4'h3;
  localparam logic [3:0] M_LUT = 4'h4;
  localparam logic [3:0] M_EST = 4'h5;
  localparam logic [3:0] M_COV = 4'h6;
  localparam logic [3:0] M_PHASE = 4'h7;
  localparam logic [3:0] M_CMD = 4'h8;
  localparam logic [3:0] M_TW = 4'h9;
  localparam logic [3:0] M_FP = 4'ha;
  localparam logic [3:0] M_MEAS = 4'hb;

  localparam logic [1:0] BUF_FULL = 2'h2;

  typedef enum logic [1:0] {
    KIND_WOOF,
    KIND_TWEET,
    KIND_TILT
  } mcg_kind_t;

  typedef enum logic [2:0] {
    ST_VOL,
    ST_MEAS,
    ST_FIT,
    ST_SPLIT,
    ST_IFT,
    ST_LUT,
    ST_TILT
  } mcg_state_t;

  typedef struct packed {
    logic [3:0] sel;
    logic [AW-1:0] addr;
    logic signed [DW-1:0] data;
  } mcg_load_t;

  typedef struct packed {
    mcg_kind_t kind;
    logic last;
    logic [AW-1:0] idx;
    logic signed [DW-1:0] val_a;
    logic signed [DW-1:0] val_b;
  } mcg_word_t;

  // Fixed-point product with FRAC fraction bits; wraps on overflow.
  function automatic logic signed [DW-1:0] fmul(
    input logic signed [DW-1:0] a,
    input logic signed [DW-1:0] b
  );
    logic signed [2*DW-1:0] p;
    p = a * b;
    return p[FRAC+DW-1:FRAC];
  endfunction

endpackage

//--- verilog/mcg_top.sv
// Mirror command generator: woofer fit, tweeter voltages and tilt estimates.
`timescale 1ns/100ps

module mcg_top
  import mcg_pkg::*;
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic vol_valid_in,
  input wire logic signed [DW-1:0] vol_data_in,
  output logic vol_ready_out,
  input wire logic load_valid_in,
  input wire mcg_load_t load_in,
  input wire logic [AW-1:0] cov_raddr_in,
  output logic signed [DW-1:0] cov_rdata_out,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output mcg_word_t out_word_out,
  output logic step_done_out
);

  mcg_state_t state_q;
  mcg_state_t state_d;
  logic [AW-1:0] i_q;
  logic [AW-1:0] i_d;
  logic [AW-1:0] j_q;
  logic [AW-1:0] j_d;
  logic ph_q;
  logic ph_d;
  logic signed [DW-1:0] acc_a_q;
  logic signed [DW-1:0] acc_a_d;
  logic signed [DW-1:0] acc_b_q;
  logic signed [DW-1:0] acc_b_d;
  logic vol_ready_q;
  logic vol_ready_d;
  logic done_q;
  logic done_d;

  logic vol_take;
  logic push;
  mcg_word_t push_word;
  logic buf_rdy;
  logic signed [DW-1:0] ach;
  logic signed [DW-1:0] twv;
  logic signed [DW-1:0] fpv;
  logic [CW-1:0] fx;
  logic [CW-1:0] fy;
  logic in_box;

  logic mem_we [NMEM];
  logic [AW-1:0] mem_wa [NMEM];
  logic signed [DW-1:0] mem_wd [NMEM];
  logic [AW-1:0] mem_ra [NMEM];
  logic signed [DW-1:0] mem_rd [NMEM];

  mcg_word_t b0_q;
  mcg_word_t b0_d;
  mcg_word_t b1_q;
  mcg_word_t b1_d;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic out_valid_q;
  logic out_valid_d;
  logic take;
  logic pop;

  // Mirror a frequency coordinate into the in-box band it aliases from.
  function automatic logic [CW-1:0] mir(input logic [CW-1:0] c);
    int band;
    int r;
    band = int'(c) / FW;
    r = int'(c) % FW;
    if (band % 2 == 1) begin
      return CW'(FW - 1 - r);
    end
    return CW'(r);
  endfunction

  // Every table is one instance; coefficient tables are filled by loads.
  genvar g;
  generate
    for (g = 0; g < NMEM; g++) begin : g_mem
      mcg_mem u_mem (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .wr_en_in(mem_we[g]),
        .wr_addr_in(mem_wa[g]),
        .wr_data_in(mem_wd[g]),
        .rd_addr_in(mem_ra[g]),
        .rd_data_out(mem_rd[g])
      );
    end
  endgenerate

  assign vol_take = vol_valid_in && vol_ready_q;
  assign buf_rdy = (cnt_q != BUF_FULL);
  assign fx = i_q[CW-1:0];
  assign fy = i_q[2*CW-1:CW];
  assign in_box = (fx < CW'(FW)) && (fy < CW'(FW));

  always_comb begin
    state_d = state_q;
    i_d = i_q;
    j_d = j_q;
    ph_d = ph_q;
    acc_a_d = acc_a_q;
    acc_b_d = acc_b_q;
    done_d = 1'b0;
    push = 1'b0;
    push_word = '0;
    ach = fmul(mem_rd[M_W], mem_rd[M_CMD]);
    twv = DW'(mem_rd[M_PHASE] - ach);
    fpv = fmul(mem_rd[M_PHI], twv);
    for (int k = 0; k < NMEM; k++) begin
      mem_we[k] = 1'b0;
      mem_wa[k] = i_q;
      mem_wd[k] = '0;
      mem_ra[k] = i_q;
    end
    // Coefficient tables accept loads at any time, even mid-step.
    for (int k = 0; k < NLOAD; k++) begin
      mem_we[k] = load_valid_in && (load_in.sel == 4'(k));
      mem_wa[k] = load_in.addr;
      mem_wd[k] = load_in.data;
    end
    mem_ra[M_COV] = cov_raddr_in;
    case (state_q)
      ST_VOL: begin
        if (vol_take) begin
          acc_a_d = DW'((j_q == '0 ? '0 : acc_a_q) + vol_data_in);
          if (j_q == AW'(NL - 1)) begin
            mem_we[M_PHASE] = 1'b1;
            mem_wd[M_PHASE] = acc_a_d;
            j_d = '0;
            i_d = AW'(i_q + 1'b1);
            if (i_q == AW'(NE - 1)) begin
              state_d = ST_MEAS;
              i_d = '0;
            end
          end else begin
            j_d = AW'(j_q + 1'b1);
          end
        end
      end
      ST_MEAS: begin
        if (vol_take) begin
          mem_we[M_MEAS] = 1'b1;
          mem_wd[M_MEAS] = vol_data_in;
          i_d = AW'(i_q + 1'b1);
          if (i_q == AW'(NMEAS - 1)) begin
            state_d = ST_FIT;
            i_d = '0;
          end
        end
      end
      ST_FIT: begin
        if (!ph_q) begin
          ph_d = 1'b1;
        end else begin
          ph_d = 1'b0;
          mem_we[M_CMD] = 1'b1;
          if (in_box) begin
            mem_wd[M_CMD] = fmul(mem_rd[M_B], mem_rd[M_PHASE]);
          end else begin
            mem_wd[M_CMD] = '0;
          end
          i_d = AW'(i_q + 1'b1);
          if (i_q == AW'(NE - 1)) begin
            state_d = ST_SPLIT;
            i_d = '0;
          end
        end
      end
      ST_SPLIT: begin
        mem_ra[M_CMD] = AW'({mir(fy), mir(fx)});
        if (!ph_q) begin
          ph_d = 1'b1;
        end else begin
          ph_d = 1'b0;
          mem_we[M_TW] = 1'b1;
          mem_wd[M_TW] = twv;
          mem_we[M_FP] = 1'b1;
          mem_wd[M_FP] = fpv;
          push = 1'b1;
          push_word.kind = KIND_WOOF;
          push_word.idx = i_q;
          push_word.val_a = mem_rd[M_CMD];
          push_word.val_b = ach;
          i_d = AW'(i_q + 1'b1);
          if (i_q == AW'(NE - 1)) begin
            state_d = ST_IFT;
            i_d = '0;
            j_d = '0;
          end
        end
      end
      ST_IFT: begin
        mem_ra[M_KER] = AW'(i_q * AW'(NE) + j_q);
        mem_ra[M_TW] = j_q;
        mem_ra[M_FP] = j_q;
        if (!ph_q) begin
          ph_d = 1'b1;
        end else begin
          ph_d = 1'b0;
          // Kernel rows hold the inverse transform weights per actuator.
          acc_a_d = DW'((j_q == '0 ? '0 : acc_a_q)
                    + fmul(mem_rd[M_KER], mem_rd[M_TW]));
          acc_b_d = DW'((j_q == '0 ? '0 : acc_b_q)
                    + fmul(mem_rd[M_KER], mem_rd[M_FP]));
          if (j_q == AW'(NE - 1)) begin
            state_d = ST_LUT;
            j_d = '0;
          end else begin
            j_d = AW'(j_q + 1'b1);
          end
        end
      end
      ST_LUT: begin
        // Sign bits are inverted so the table index rises with the value.
        mem_ra[M_LUT] = {~acc_b_q[DW-1], acc_b_q[DW-2 -: LUT_BITS-1],
                         ~acc_a_q[DW-1], acc_a_q[DW-2 -: LUT_BITS-1]};
        if (!ph_q) begin
          ph_d = 1'b1;
        end else begin
          ph_d = 1'b0;
          push = 1'b1;
          push_word.kind = KIND_TWEET;
          push_word.idx = i_q;
          push_word.val_a = mem_rd[M_LUT];
          push_word.val_b = acc_a_q;
          i_d = AW'(i_q + 1'b1);
          if (i_q == AW'(NE - 1)) begin
            state_d = ST_TILT;
            i_d = '0;
          end else begin
            state_d = ST_IFT;
          end
        end
      end
      ST_TILT: begin
        mem_ra[M_EST] = AW'(i_q * AW'(NMEAS) + j_q);
        mem_ra[M_MEAS] = j_q;
        if (!ph_q) begin
          ph_d = 1'b1;
        end else begin
          ph_d = 1'b0;
          acc_a_d = DW'((j_q == '0 ? '0 : acc_a_q)
                    + fmul(mem_rd[M_EST], mem_rd[M_MEAS]));
          if (j_q == AW'(NMEAS - 1)) begin
            push = 1'b1;
            push_word.kind = KIND_TILT;
            push_word.idx = i_q;
            push_word.val_a = acc_a_d;
            push_word.last = (i_q == AW'(NTILT - 1));
            j_d = '0;
            i_d = AW'(i_q + 1'b1);
            if (i_q == AW'(NTILT - 1)) begin
              state_d = ST_VOL;
              i_d = '0;
              done_d = 1'b1;
            end
          end else begin
            j_d = AW'(j_q + 1'b1);
          end
        end
      end
      default: begin
        state_d = ST_VOL;
        i_d = '0;
        j_d = '0;
        ph_d = 1'b0;
      end
    endcase
    // A push into a full buffer freezes the engine; held addresses keep read data valid.
    if (push && !buf_rdy) begin
      state_d = state_q;
      i_d = i_q;
      j_d = j_q;
      ph_d = ph_q;
      acc_a_d = acc_a_q;
      acc_b_d = acc_b_q;
      done_d = 1'b0;
      for (int k = NLOAD; k < NMEM; k++) begin
        mem_we[k] = 1'b0;
      end
    end
    vol_ready_d = (state_d == ST_VOL) || (state_d == ST_MEAS);
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= ST_VOL;
      i_q <= '0;
      j_q <= '0;
      ph_q <= 1'b0;
      acc_a_q <= '0;
      acc_b_q <= '0;
      vol_ready_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      i_q <= i_d;
      j_q <= j_d;
      ph_q <= ph_d;
      acc_a_q <= acc_a_d;
      acc_b_q <= acc_b_d;
      vol_ready_q <= vol_ready_d;
      done_q <= done_d;
    end
  end

  // Two-entry output buffer so a receiver stall loses no word.
  always_comb begin
    b0_d = b0_q;
    b1_d = b1_q;
    cnt_d = cnt_q;
    take = push && buf_rdy;
    pop = out_valid_q && out_ready_in;
    case ({take, pop})
      2'b10: begin
        if (cnt_q == 2'h0) begin
          b0_d = push_word;
        end else begin
          b1_d = push_word;
        end
        cnt_d = 2'(cnt_q + 2'h1);
      end
      2'b01: begin
        b0_d = b1_q;
        cnt_d = 2'(cnt_q - 2'h1);
      end
      2'b11: begin
        if (cnt_q == 2'h1) begin
          b0_d = push_word;
        end else begin
          b0_d = b1_q;
          b1_d = push_word;
        end
      end
      default: begin
        cnt_d = cnt_q;
      end
    endcase
    out_valid_d = (cnt_d != 2'h0);
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      b0_q <= '0;
      b1_q <= '0;
      cnt_q <= 2'h0;
      out_valid_q <= 1'b0;
    end else begin
      b0_q <= b0_d;
      b1_q <= b1_d;
      cnt_q <= cnt_d;
      out_valid_q <= out_valid_d;
    end
  end

  assign vol_ready_out = vol_ready_q;
  assign cov_rdata_out = mem_rd[M_COV];
  assign out_valid_out = out_valid_q;
  assign out_word_out = b0_q;
  assign step_done_out = done_q;

endmodule
